/* swscl_top.sv */
// Purpose: Slave command layer of a single-wire open-drain link: slots, reset/presence, net address, functions
// Assumes: Memory answers rd_data_i combinationally from mem_req_o.addr; it carries out copy/recall/lock pulses
// Notes: Line sampled through three flops; output is open drain only, enable low while pulling
// Functional notes
// - Line is driven only open drain: pulled low or released, never driven high.
// - Low over 120 us is a reset and abandons work; master idles high to suspend.
// - Each transaction: reset, presence, one net address command, one function, then data.
// - Read net address is 33h or 39h by opcode select; sends 64-bit address.
// - Match 55h plus 64 bits: answer only on equal address, else wait for reset.
// - Skip CCh goes straight to function command without address bits.
// - Search F0h: per bit send bit, complement, then read master's choice, 64 times.
// - Resume A5h acts as skip only when selection flag set by match or search.
// - Read 69h plus address: data from that address, incrementing after each byte.
// - Read address wraps FFh to 00; reset may end read anywhere.
// - Write 6Ch plus address: store bytes from there, incrementing, wrapping past FFh.
// - Drop writes to protected or locked places and partial bytes; EEPROM goes to shadow.
// - Copy 48h copies the 4-byte block to EEPROM unless locked or asleep.
// - Copy starts at next falling edge; busy flag high meanwhile blocks EEPROM writes.
// - Recall B8h loads the 4-byte EEPROM block into shadow RAM.
// - Lock 6Ah locks block only if lock enable set by immediately preceding write.
// - Net address: family code low byte, 48-bit serial, CRC of 56 bits on top.
// - After reset ends, wait presence-high time, then pull low for presence.
// - Master write slots are sampled 15 to 60 us after the falling edge.
// - A carried-out lock clears the lock-enable bit.
module swscl_top #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A,        // Arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0123456789AB // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_n_o,
  input wire logic net_address_opcode_select_i,
  input wire swscl_pkg::swscl_mem_stat_t mem_stat_i,
  input wire logic [7:0] rd_data_i,
  output swscl_pkg::swscl_mem_req_t mem_req_o,
  output logic selected_o,
  output logic lock_enable_o
);

  localparam logic [55:0] LOW56 = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] NET_ADDR = {swscl_pkg::crc56(LOW56), LOW56};

  swscl_pkg::swscl_state_t r;
  swscl_pkg::swscl_state_t n;
  logic new_f;
  logic fall;
  logic rise;
  logic bit_done;
  logic rx;
  logic tx_bit;
  logic tx_phase;
  logic [7:0] byte_in;
  logic na_bit;
  logic ee_ok;

  always_comb begin
    n = r;
    n.mreq.wr = 1'b0;
    n.mreq.copy = 1'b0;
    n.mreq.recall = 1'b0;
    n.mreq.lock = 1'b0;
    n.s1 = dq_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    new_f = (r.s2 == r.s3) ? r.s3 : r.dq_f;
    n.dq_f = new_f;
    fall = r.dq_f & ~new_f;
    rise = ~r.dq_f & new_f;
    n.tick = 1'b0;
    n.div = r.div + 5'h01;
    if (r.div == 5'(swscl_pkg::CYC_PER_US - 1)) begin
      n.div = 5'h00;
      n.tick = 1'b1;
    end
    if (r.tick && r.us_cnt != 10'h3FF) begin
      n.us_cnt = r.us_cnt + 10'h001;
    end
    na_bit = NET_ADDR[r.bitn];
    ee_ok = swscl_pkg::is_eeprom(r.mreq.addr) && !r.mreq.addr[swscl_pkg::EE_BLK_SEL_BIT] ?
            !mem_stat_i.block_locked[0] : !mem_stat_i.block_locked[1];
    unique case (r.phase)
      swscl_pkg::PH_ROM_TX: begin
        tx_phase = 1'b1;
        tx_bit = na_bit;
      end
      swscl_pkg::PH_SEARCH: begin
        tx_phase = (r.step != 2'h2);
        tx_bit = (r.step == 2'h0) ? na_bit : ~na_bit;
      end
      swscl_pkg::PH_READ: begin
        tx_phase = 1'b1;
        tx_bit = rd_data_i[r.bitn[2:0]];
      end
      default: begin
        tx_phase = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
    bit_done = r.in_slot && r.tick && (r.us_cnt == swscl_pkg::SAMPLE_US);
    rx = r.dq_f;
    byte_in = {rx, r.sh[7:1]};
    if (r.phase == swscl_pkg::PH_PDH) begin
      if (r.tick && r.us_cnt == swscl_pkg::PDH_US) begin
        n.phase = swscl_pkg::PH_PDL;
        n.drive_n = 1'b0;
        n.us_cnt = 10'h000;
      end
    end else if (r.phase == swscl_pkg::PH_PDL) begin
      if (r.tick && r.us_cnt == swscl_pkg::PDL_US) begin
        n.drive_n = 1'b1;
        n.phase = swscl_pkg::PH_ROM_CMD;
        n.bitn = 6'h00;
        n.in_slot = 1'b0;
      end
    end else if (r.phase == swscl_pkg::PH_RSTL) begin
      if (rise) begin
        n.phase = swscl_pkg::PH_PDH;
        n.us_cnt = 10'h000;
      end
    end else if (!r.dq_f && r.drive_n && r.us_cnt >= swscl_pkg::RSTL_US) begin
      // Long low abandons whatever was in progress
      n.phase = swscl_pkg::PH_RSTL;
      n.in_slot = 1'b0;
      // Arming must outlive the reset that ends the arming write; the next function command decides
      n.lock_armed = r.lock_armed;
    end else if (fall) begin
      n.us_cnt = 10'h000;
      if (r.phase == swscl_pkg::PH_COPYW) begin
        n.mreq.copy = 1'b1;
        n.phase = swscl_pkg::PH_DONE;
      end else if (r.phase != swscl_pkg::PH_IDLE && r.phase != swscl_pkg::PH_DONE) begin
        n.in_slot = 1'b1;
        n.drive_n = ~(tx_phase & ~tx_bit);
      end
    end else if (bit_done) begin
      n.in_slot = 1'b0;
      n.drive_n = 1'b1;
      n.sh = byte_in;
      n.bitn = r.bitn + 6'h01;
      unique case (r.phase)
        swscl_pkg::PH_ROM_CMD: begin
          if (r.bitn[2:0] == 3'h7) begin
            n.bitn = 6'h00;
            n.step = 2'h0;
            n.match_ok = 1'b1;
            n.selected = 1'b0;
            n.phase = swscl_pkg::PH_DONE;
            if (byte_in == (net_address_opcode_select_i ? swscl_pkg::OP_READ_NA1 : swscl_pkg::OP_READ_NA0)) begin
              n.phase = swscl_pkg::PH_ROM_TX;
            end else if (byte_in == swscl_pkg::OP_MATCH) begin
              n.phase = swscl_pkg::PH_MATCH;
            end else if (byte_in == swscl_pkg::OP_SKIP) begin
              n.phase = swscl_pkg::PH_FN_CMD;
            end else if (byte_in == swscl_pkg::OP_SEARCH) begin
              n.phase = swscl_pkg::PH_SEARCH;
            end else if (byte_in == swscl_pkg::OP_RESUME) begin
              n.selected = r.selected;
              n.phase = r.selected ? swscl_pkg::PH_FN_CMD : swscl_pkg::PH_DONE;
            end
          end
        end
        swscl_pkg::PH_ROM_TX: begin
          if (r.bitn == 6'h3F) begin
            n.bitn = 6'h00;
            n.phase = swscl_pkg::PH_FN_CMD;
          end
        end
        swscl_pkg::PH_MATCH: begin
          n.match_ok = r.match_ok && (rx == na_bit);
          if (r.bitn == 6'h3F) begin
            n.bitn = 6'h00;
            n.selected = n.match_ok;
            n.phase = n.match_ok ? swscl_pkg::PH_FN_CMD : swscl_pkg::PH_DONE;
          end
        end
        swscl_pkg::PH_SEARCH: begin
          n.bitn = r.bitn;
          n.step = r.step + 2'h1;
          if (r.step == 2'h2) begin
            n.step = 2'h0;
            n.bitn = r.bitn + 6'h01;
            if (rx != na_bit) begin
              n.phase = swscl_pkg::PH_DONE;
            end else if (r.bitn == 6'h3F) begin
              n.bitn = 6'h00;
              n.selected = 1'b1;
              n.phase = swscl_pkg::PH_FN_CMD;
            end
          end
        end
        swscl_pkg::PH_FN_CMD: begin
          if (r.bitn[2:0] == 3'h7) begin
            n.bitn = 6'h00;
            n.opc = byte_in;
            n.phase = swscl_pkg::PH_FN_ADDR;
            if (byte_in != swscl_pkg::OP_LOCK) begin
              n.lock_armed = 1'b0;
            end
          end
        end
        swscl_pkg::PH_FN_ADDR: begin
          if (r.bitn[2:0] == 3'h7) begin
            n.bitn = 6'h00;
            n.mreq.addr = byte_in;
            n.phase = swscl_pkg::PH_DONE;
            if (r.opc == swscl_pkg::OP_RD) begin
              n.phase = swscl_pkg::PH_READ;
            end else if (r.opc == swscl_pkg::OP_WR) begin
              n.phase = swscl_pkg::PH_WRITE;
            end else if (swscl_pkg::is_eeprom(byte_in)) begin
              // Recompute lock state from the fresh address, not the stale one
              ee_ok = !mem_stat_i.block_locked[byte_in[swscl_pkg::EE_BLK_SEL_BIT]];
              if (r.opc == swscl_pkg::OP_COPY && ee_ok && !mem_stat_i.sleep) begin
                n.phase = swscl_pkg::PH_COPYW;
              end else if (r.opc == swscl_pkg::OP_RECALL) begin
                n.mreq.recall = 1'b1;
              end else if (r.opc == swscl_pkg::OP_LOCK && r.lock_en && r.lock_armed && !mem_stat_i.sleep) begin
                n.mreq.lock = 1'b1;
                n.lock_en = 1'b0;
              end
            end
            n.lock_armed = 1'b0;
          end
        end
        swscl_pkg::PH_READ: begin
          if (r.bitn[2:0] == 3'h7) begin
            n.bitn = 6'h00;
            n.mreq.addr = r.mreq.addr + 8'h01;
          end
        end
        swscl_pkg::PH_WRITE: begin
          if (r.bitn[2:0] == 3'h7) begin
            n.bitn = 6'h00;
            n.mreq.addr = r.mreq.addr + 8'h01;
            // Only whole bytes reach memory; protected targets are dropped
            if (mem_stat_i.writable && !(swscl_pkg::is_eeprom(r.mreq.addr) && (!ee_ok || mem_stat_i.copy_busy))) begin
              n.mreq.wr = 1'b1;
              n.mreq.wdata = byte_in;
            end
            n.lock_armed = (r.mreq.addr == swscl_pkg::LOCK_REG_ADDR) && byte_in[swscl_pkg::LOCK_EN_BIT];
            if (r.mreq.addr == swscl_pkg::LOCK_REG_ADDR) begin
              n.lock_en = byte_in[swscl_pkg::LOCK_EN_BIT];
            end
          end
        end
        default: begin
          n.bitn = r.bitn;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, dq_f: 1'b1, phase: swscl_pkg::PH_IDLE, drive_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign dq_o = 1'b0;
  assign dq_oe_n_o = r.drive_n;
  assign mem_req_o = r.mreq;
  assign selected_o = r.selected;
  assign lock_enable_o = r.lock_en;

  sequence s_reset_seen;
    r.phase == swscl_pkg::PH_RSTL && rise;
  endsequence
  sequence s_presence;
    r.phase == swscl_pkg::PH_PDH ##[1:500] r.phase == swscl_pkg::PH_PDL && !dq_oe_n_o;
  endsequence

  a_drive_only_slots: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !dq_oe_n_o |-> (r.phase == swscl_pkg::PH_PDL || r.in_slot)) else $error("line pulled outside slot");
  a_long_low_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (r.phase != swscl_pkg::PH_RSTL && r.phase != swscl_pkg::PH_PDH && r.phase != swscl_pkg::PH_PDL
     && r.drive_n && !r.dq_f && r.us_cnt >= swscl_pkg::RSTL_US) |=> r.phase == swscl_pkg::PH_RSTL)
    else $error("long low not taken as reset");
  a_presence_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_reset_seen |=> s_presence) else $error("no presence after reset");
  a_rom_after_pres: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(r.phase == swscl_pkg::PH_PDL) |-> r.phase == swscl_pkg::PH_ROM_CMD) else $error("bad phase after presence");
  a_select_source: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(r.selected) |-> r.phase == swscl_pkg::PH_FN_CMD && $past(r.phase == swscl_pkg::PH_MATCH
    || r.phase == swscl_pkg::PH_SEARCH)) else $error("selection set without match or search");
  a_read_advance: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (bit_done && r.phase == swscl_pkg::PH_READ && r.bitn[2:0] == 3'h7)
    |=> r.mreq.addr == $past(r.mreq.addr) + 8'h01) else $error("read address not advanced");
  a_write_whole: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_req_o.wr |-> $past(bit_done && r.phase == swscl_pkg::PH_WRITE && r.bitn[2:0] == 3'h7))
    else $error("partial byte written");
  a_copy_on_fall: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_req_o.copy |-> $past(r.phase == swscl_pkg::PH_COPYW && fall) ##1 !mem_req_o.copy)
    else $error("copy not started on falling edge");
  a_lock_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_req_o.lock |-> !lock_enable_o && $past(r.lock_armed)) else $error("lock without arming");

endmodule : swscl_top

/* swscl_pkg.sv */
// Purpose: Shared constants, types and helpers for the single-wire slave command layer
// Assumes: 20 MHz core clock; line times counted in whole microseconds
// Notes: Net address helper computes the check byte; swscl_top builds the 64-bit address
package swscl_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned US_W = 10;

  // Line times in microseconds
  localparam logic [9:0] RSTL_US = 10'h078;   // 120 us low means reset
  localparam logic [9:0] PDH_US = 10'h014;    // 20 us wait before presence
  localparam logic [9:0] PDL_US = 10'h064;    // 100 us presence, below reset threshold
  localparam logic [9:0] SAMPLE_US = 10'h01E; // 30 us: sample and end of our low drive

  // Net address commands
  localparam logic [7:0] OP_READ_NA0 = 8'h33;
  localparam logic [7:0] OP_READ_NA1 = 8'h39;
  localparam logic [7:0] OP_MATCH = 8'h55;
  localparam logic [7:0] OP_SKIP = 8'hCC;
  localparam logic [7:0] OP_SEARCH = 8'hF0;
  localparam logic [7:0] OP_RESUME = 8'hA5;
  // Function commands
  localparam logic [7:0] OP_RD = 8'h69;
  localparam logic [7:0] OP_WR = 8'h6C;
  localparam logic [7:0] OP_COPY = 8'h48;
  localparam logic [7:0] OP_RECALL = 8'hB8;
  localparam logic [7:0] OP_LOCK = 8'h6A;

  // Memory layout seen by this block
  localparam logic [7:0] LOCK_REG_ADDR = 8'h07;
  localparam int unsigned LOCK_EN_BIT = 6;
  localparam logic [3:0] EE_BLK0_HI = 4'h2;
  localparam logic [3:0] EE_BLK1_HI = 4'h3;
  localparam logic [1:0] EE_BLK_OFS = 2'h0;
  localparam int unsigned EE_BLK_SEL_BIT = 4;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0000,
    PH_RSTL = 4'b0001,
    PH_PDH = 4'b0010,
    PH_PDL = 4'b0011,
    PH_ROM_CMD = 4'b0100,
    PH_ROM_TX = 4'b0101,
    PH_MATCH = 4'b0110,
    PH_SEARCH = 4'b0111,
    PH_FN_CMD = 4'b1000,
    PH_FN_ADDR = 4'b1001,
    PH_READ = 4'b1010,
    PH_WRITE = 4'b1011,
    PH_COPYW = 4'b1100,
    PH_DONE = 4'b1101
  } swscl_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic copy;
    logic recall;
    logic lock;
  } swscl_mem_req_t;

  typedef struct packed {
    logic [1:0] block_locked;
    logic copy_busy;
    logic sleep;
    logic writable;
  } swscl_mem_stat_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic dq_f;
    swscl_phase_t phase;
    logic in_slot;
    logic drive_n;
    logic [4:0] div;
    logic tick;
    logic [9:0] us_cnt;
    logic [5:0] bitn;
    logic [1:0] step;
    logic [7:0] sh;
    logic [7:0] opc;
    logic match_ok;
    logic selected;
    logic lock_en;
    logic lock_armed;
    swscl_mem_req_t mreq;
  } swscl_state_t;

  // Reflected CRC-8 over the low 56 address bits, least significant bit first
  function automatic logic [7:0] crc56(input logic [55:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
    end
    return c;
  endfunction : crc56

  function automatic logic is_eeprom(input logic [7:0] a);
    return ((a[7:4] == EE_BLK0_HI) || (a[7:4] == EE_BLK1_HI)) && (a[3:2] == EE_BLK_OFS);
  endfunction : is_eeprom

endpackage : swscl_pkg

/* swscl_host_model.sv */
// Purpose: Bus master model for the single-wire link: reset, write and read slots
// Assumes: Pull-up on the line; slot timing counted in core clock cycles of 50 ns
// Notes: Slots are 33 us, just past the device's 30-31 us sample, to keep the run brief
module swscl_host_model (
  input wire logic core_clk_i,
  input wire logic dq_i,
  output logic dq_pull_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC_US = 20;

  // Idle high between transactions so a pause is never taken as a reset
  initial dq_pull_n_o = 1'b1;

  task automatic wait_us(input int n);
    repeat (n * CYC_US) @(posedge core_clk_i);
  endtask : wait_us

  // Opens every transaction; also used to end copy, recall and lock
  task automatic bus_reset(output int first_low, output int low_cnt);
    first_low = -1;
    low_cnt = 0;
    dq_pull_n_o <= 1'b0;
    wait_us(125);
    dq_pull_n_o <= 1'b1;
    for (int i = 0; i < 150 * CYC_US; i++) begin
      @(posedge core_clk_i);
      if (dq_i === 1'b0) begin
        low_cnt++;
        if (first_low < 0) begin
          first_low = i;
        end
      end
    end
    wait_us(2);
  endtask : bus_reset

  // A one is released at 2 us, a zero held past the device's 30 us sample
  task automatic write_bit(input logic b);
    dq_pull_n_o <= 1'b0;
    wait_us(b ? 2 : 32);
    dq_pull_n_o <= 1'b1;
    wait_us(b ? 31 : 1);
  endtask : write_bit

  task automatic read_bit(output logic b);
    dq_pull_n_o <= 1'b0;
    wait_us(1);
    dq_pull_n_o <= 1'b1;
    wait_us(12);
    b = dq_i;
    wait_us(20);
  endtask : read_bit

  task automatic write_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      write_bit(d[i]);
    end
  endtask : write_byte

  task automatic read_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      read_bit(d[i]);
    end
  endtask : read_byte
endmodule : swscl_host_model

/* swscl_bench.sv */
// Purpose: Self-checking bench for the slave command layer against a bus master model
// Assumes: Single slave on the line, so read net address and skip are safe
// Notes: Memory is a simple model: read data is the address XOR 3Ch
module swscl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] FAM = 8'hC3; // Arbitrary value
  localparam logic [47:0] SER = 48'h13579BDF2468; // Arbitrary value

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic dq_pull_n;
  wire logic dq_line;
  logic dq_o;
  logic dq_oe_n_o;
  logic selected;
  logic lock_enable;
  logic [7:0] rd_data;
  swscl_pkg::swscl_mem_stat_t mem_stat = '{block_locked: 2'h0, copy_busy: 1'b0, sleep: 1'b0, writable: 1'b1};
  swscl_pkg::swscl_mem_req_t mem_req;
  int num_errors = 0;
  int checks = 0;
  logic [15:0] wr_log[$];
  int n_pulse[3] = '{0, 0, 0};
  logic [7:0] a_pulse[3];

  always #25 core_clk = ~core_clk;

  // Open drain: the device can only pull low, the pull-up supplies the high
  assign dq_line = dq_pull_n & (dq_oe_n_o ? 1'b1 : dq_o);
  assign rd_data = mem_req.addr ^ 8'h3C;

  swscl_top #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_swscl_top (
    .core_clk_i(core_clk),
    .rst_n_i(rst_n),
    .dq_i(dq_line),
    .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o),
    .net_address_opcode_select_i(sel),
    .mem_stat_i(mem_stat),
    .rd_data_i(rd_data),
    .mem_req_o(mem_req),
    .selected_o(selected),
    .lock_enable_o(lock_enable)
  );

  swscl_host_model u_swscl_host_model (
    .core_clk_i(core_clk),
    .dq_i(dq_line),
    .dq_pull_n_o(dq_pull_n)
  );

  task automatic summarize();
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Host-side check byte, computed here with its own loop but the design package's polynomial
  function automatic logic [7:0] host_crc(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? swscl_pkg::CRC_POLY_REFL : 8'h00);
    end
    return c;
  endfunction : host_crc

  task automatic init_seq();
    int fl;
    int lc;
    u_swscl_host_model.bus_reset(fl, lc);
    check("presence_delay", (fl >= 300 && fl <= 1200), 1'b1);
    check("presence_len", (lc >= 1200 && lc <= 4800), 1'b1);
  endtask : init_seq

  task automatic wb(input logic [7:0] d);
    u_swscl_host_model.write_byte(d);
  endtask : wb

  task automatic rb_expect(input string name, input logic [7:0] exp);
    logic [7:0] d;
    u_swscl_host_model.read_byte(d);
    check(name, d, exp);
  endtask : rb_expect

  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && dq_oe_n_o === 1'b0) begin
      check("dq_o", dq_o, 1'b0);
    end
    if (mem_req.wr === 1'b1) begin
      wr_log.push_back({mem_req.addr - 8'h01, mem_req.wdata});
    end
    if (mem_req.copy === 1'b1) begin
      n_pulse[0]++;
      a_pulse[0] = mem_req.addr;
    end
    if (mem_req.recall === 1'b1) begin
      n_pulse[1]++;
      a_pulse[1] = mem_req.addr;
    end
    if (mem_req.lock === 1'b1) begin
      n_pulse[2]++;
      a_pulse[2] = mem_req.addr;
    end
  end

  initial begin
    // About 13.4 ms of line traffic; the margin covers slot rounding
    #20_000_000;
    num_errors++;
    summarize();
  end

  initial begin
    logic [63:0] na;
    logic [7:0] ops[2];
    logic [7:0] adr[2];
    ops = '{8'h48, 8'hB8};
    adr = '{8'h21, 8'h32};
    na = {host_crc({SER, FAM}), SER, FAM};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    sel <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("oe_idle", dq_oe_n_o, 1'b1);
    // The opcode not selected must leave the line released
    init_seq();
    wb(8'h33);
    rb_expect("rna_refused", 8'hFF);
    init_seq();
    wb(8'h39);
    for (int i = 0; i < 8; i++) begin
      rb_expect("net_address", na[8 * i +: 8]);
    end
    // Same transaction goes on to a read across the top of the address space
    wb(8'h69);
    wb(8'hFF);
    rb_expect("read_ff", 8'hFF ^ 8'h3C);
    rb_expect("read_wrap", 8'h00 ^ 8'h3C);
    // Write wraps, and a half byte cut by a reset is dropped
    sel <= 1'b0;
    init_seq();
    wb(8'hCC);
    wb(8'h6C);
    wb(8'hFE);
    wb(8'h11);
    wb(8'h22);
    wb(8'h33);
    for (int i = 0; i < 4; i++) begin
      u_swscl_host_model.write_bit(1'b1);
    end
    init_seq();
    check("wr_count", wr_log.size(), 3);
    check("wr_0", wr_log[0], 16'hFE11);
    check("wr_1", wr_log[1], 16'hFF22);
    check("wr_2", wr_log[2], 16'h0033);
    // Copy after a match waits for the next falling edge; recall under resume follows its address byte
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        wb(8'h55);
        for (int i = 0; i < 8; i++) begin
          wb(na[8 * i +: 8]);
        end
        check("selected_match", selected, 1'b1);
      end else begin
        wb(8'hA5);
      end
      wb(ops[k]);
      wb(adr[k]);
      if (k == 0) begin
        check("copy_wait", n_pulse[0], 0);
      end
      init_seq();
      check("pulse_count", n_pulse[k], 1);
      check("pulse_addr", a_pulse[k], adr[k]);
    end
    // Arm the lock, then lock in the very next transaction
    wb(8'hCC);
    check("selected_skip", selected, 1'b0);
    wb(8'h6C);
    wb(swscl_pkg::LOCK_REG_ADDR);
    wb(8'h40);
    init_seq();
    check("lock_armed", lock_enable, 1'b1);
    wb(8'hCC);
    wb(8'h6A);
    wb(8'h22);
    init_seq();
    check("lock_count", n_pulse[2], 1);
    check("lock_addr", a_pulse[2], 8'h22);
    check("lock_cleared", lock_enable, 1'b0);
    summarize();
  end
endmodule : swscl_bench
